/* shared/tcio_consts.svh */
`ifndef TCIO_CONSTS_SVH
`define TCIO_CONSTS_SVH

// Register map, byte offsets on the plain register port.
`define TCIO_ADDR_W        3
`define TCIO_OFF_CH0_AB    3'h0
`define TCIO_OFF_CH0_CD    3'h1
`define TCIO_OFF_CH1       3'h2
`define TCIO_OFF_CH2       3'h3
`define TCIO_OFF_CTRL      3'h4
`define TCIO_OFF_STAT      3'h5

// Reset values.
`define TCIO_RST_IOCTL     8'h00
`define TCIO_RST_CTRL      8'h00

// Function select field layout.
`define TCIO_FLD_LO_MSB    3
`define TCIO_FLD_LO_LSB    0
`define TCIO_FLD_HI_MSB    7
`define TCIO_FLD_HI_LSB    4
`define TCIO_FLD_CAP       3
`define TCIO_FLD_INIT      2
`define TCIO_ACT_OFF       2'h0
`define TCIO_ACT_LOW       2'h1
`define TCIO_ACT_HIGH      2'h2
`define TCIO_ACT_TOGGLE    2'h3

// Control register layout: count start bits per channel, buffer mode.
`define TCIO_CTRL_CST0     0
`define TCIO_CTRL_CST1     1
`define TCIO_CTRL_CST2     2
`define TCIO_CTRL_BUFA     4

// Number of register units handled here.
`define TCIO_UNITS         5
`define TCIO_CNT_W         16

`endif

/* shared/tcio_pkg.sv */
`default_nettype none

package tcio_pkg;

  typedef enum logic [1:0] {
    FN_OFF,
    FN_CMP,
    FN_CAP,
    FN_BAD
  } tcio_func_e;

endpackage

`default_nettype wire

/* hw/tcio_top.sv */
// Operation
// - Low nibble of each channel control register picks register A use.
// - Channel 0 second control register low nibble picks register C use.
// - Code 0x01 is compare; pin goes low on match.
// - Code 0x10 is compare; pin goes high on match.
// - Code 0x11 is compare; pin toggles on each match.
// - For compare codes bit 2 gives the initial pin level.
// - Code 1000 captures the counter on a rising pin edge.
// - Capture code with low bits 01 captures on a falling edge.
// - Capture code with bit 1 set captures on both edges.
// - Each capture register watches only its own dedicated channel pin.
// - In channel 2, bit 3 set selects capture regardless of bit 2.
// - Buffer mode on register C voids its setting and all its events.
// - Initial pin level applies only while the channel count is halted.
`timescale 1ns/1ns
`include "tcio_consts.svh"
`default_nettype none

module tcio_top (
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic [`TCIO_ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]               regWrData,
  input  wire logic                     regWrStb,
  input  wire logic                     regRdStb,
  output logic      [7:0]               regRdData,
  input  wire logic [`TCIO_CNT_W-1:0]   ch0Count,
  input  wire logic [`TCIO_CNT_W-1:0]   ch1Count,
  input  wire logic [`TCIO_CNT_W-1:0]   ch2Count,
  input  wire logic [`TCIO_UNITS-1:0]   cmpMatch,
  input  wire logic [`TCIO_UNITS-1:0]   pinIn,
  output logic      [`TCIO_UNITS-1:0]   pinOut,
  output logic      [`TCIO_UNITS-1:0]   pinOeN,
  output logic      [`TCIO_UNITS-1:0]   capEvt,
  output logic      [`TCIO_UNITS-1:0]   cmpEvt,
  output logic      [`TCIO_UNITS-1:0][`TCIO_CNT_W-1:0] capValue
);
  import tcio_pkg::*;

  logic [7:0] ioCh0Ab_reg;
  logic [7:0] ioCh0Cd_reg;
  logic [7:0] ioCh1_reg;
  logic [7:0] ioCh2_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] rdData_next;

  logic [3:0]             field     [`TCIO_UNITS];
  logic                   running   [`TCIO_UNITS];
  logic                   blocked   [`TCIO_UNITS];
  logic                   isCh2     [`TCIO_UNITS];
  logic [`TCIO_CNT_W-1:0] countOf   [`TCIO_UNITS];
  logic                   pinOut_reg [`TCIO_UNITS];
  logic                   pinOeN_reg [`TCIO_UNITS];
  logic                   pinPrev_reg [`TCIO_UNITS];
  logic                   capEvt_reg [`TCIO_UNITS];
  logic                   cmpEvt_reg [`TCIO_UNITS];
  logic [`TCIO_CNT_W-1:0] capVal_reg [`TCIO_UNITS];

  // Register writes. Unmapped offsets are ignored.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ioCh0Ab_reg <= `TCIO_RST_IOCTL;
      ioCh0Cd_reg <= `TCIO_RST_IOCTL;
      ioCh1_reg   <= `TCIO_RST_IOCTL;
      ioCh2_reg   <= `TCIO_RST_IOCTL;
      ctrl_reg    <= `TCIO_RST_CTRL;
    end else if (regWrStb) begin
      case (regAddr)
        `TCIO_OFF_CH0_AB: ioCh0Ab_reg <= regWrData;
        `TCIO_OFF_CH0_CD: ioCh0Cd_reg <= regWrData;
        `TCIO_OFF_CH1:    ioCh1_reg   <= regWrData;
        `TCIO_OFF_CH2:    ioCh2_reg   <= regWrData;
        `TCIO_OFF_CTRL:   ctrl_reg    <= regWrData;
        default: ;
      endcase
    end
  end

  // Read data stands for one cycle only, zero otherwise.
  always_comb begin
    rdData_next = 8'h00;
    if (regRdStb) begin
      case (regAddr)
        `TCIO_OFF_CH0_AB: rdData_next = ioCh0Ab_reg;
        `TCIO_OFF_CH0_CD: rdData_next = ioCh0Cd_reg;
        `TCIO_OFF_CH1:    rdData_next = ioCh1_reg;
        `TCIO_OFF_CH2:    rdData_next = ioCh2_reg;
        `TCIO_OFF_CTRL:   rdData_next = ctrl_reg;
        `TCIO_OFF_STAT:   rdData_next = {3'h0, pinOut};
        default:          rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= rdData_next;
    end
  end

  // Unit order: ch0 A, ch0 C, ch1 A, ch2 A, ch2 B.
  assign field[0] = ioCh0Ab_reg[`TCIO_FLD_LO_MSB:`TCIO_FLD_LO_LSB];
  assign field[1] = ioCh0Cd_reg[`TCIO_FLD_LO_MSB:`TCIO_FLD_LO_LSB];
  assign field[2] = ioCh1_reg[`TCIO_FLD_LO_MSB:`TCIO_FLD_LO_LSB];
  assign field[3] = ioCh2_reg[`TCIO_FLD_LO_MSB:`TCIO_FLD_LO_LSB];
  assign field[4] = ioCh2_reg[`TCIO_FLD_HI_MSB:`TCIO_FLD_HI_LSB];

  assign running[0] = ctrl_reg[`TCIO_CTRL_CST0];
  assign running[1] = ctrl_reg[`TCIO_CTRL_CST0];
  assign running[2] = ctrl_reg[`TCIO_CTRL_CST1];
  assign running[3] = ctrl_reg[`TCIO_CTRL_CST2];
  assign running[4] = ctrl_reg[`TCIO_CTRL_CST2];

  assign countOf[0] = ch0Count;
  assign countOf[1] = ch0Count;
  assign countOf[2] = ch1Count;
  assign countOf[3] = ch2Count;
  assign countOf[4] = ch2Count;

  assign isCh2[0] = 1'b0;
  assign isCh2[1] = 1'b0;
  assign isCh2[2] = 1'b0;
  assign isCh2[3] = 1'b1;
  assign isCh2[4] = 1'b1;

  // Only register C of channel 0 can be turned into a buffer.
  assign blocked[0] = 1'b0;
  assign blocked[1] = ctrl_reg[`TCIO_CTRL_BUFA];
  assign blocked[2] = 1'b0;
  assign blocked[3] = 1'b0;
  assign blocked[4] = 1'b0;

  genvar u;
  generate
    for (u = 0; u < `TCIO_UNITS; u++) begin : g_unit
      tcio_func_e func;
      logic       rise;
      logic       fall;
      logic       capHit;
      logic       cmpHit;

      always_comb begin
        if (blocked[u]) begin
          func = FN_OFF;
        end else if (field[u][`TCIO_FLD_CAP] &&
                     (isCh2[u] || !field[u][`TCIO_FLD_INIT])) begin
          func = FN_CAP;
        end else if (field[u][`TCIO_FLD_CAP]) begin
          // A prohibited code leaves the unit inert rather than guessing.
          func = FN_BAD;
        end else if (field[u][1:0] == `TCIO_ACT_OFF) begin
          func = FN_OFF;
        end else begin
          func = FN_CMP;
        end
      end

      // Pins are taken as synchronous; the previous sample gives the edge.
      assign rise = pinIn[u] && !pinPrev_reg[u];
      assign fall = !pinIn[u] && pinPrev_reg[u];

      always_comb begin
        capHit = 1'b0;
        if (func == FN_CAP) begin
          if (field[u][1]) begin
            capHit = rise || fall;
          end else if (field[u][0]) begin
            capHit = fall;
          end else begin
            capHit = rise;
          end
        end
      end

      // Compare events survive with the pin disabled, but not in buffer mode.
      assign cmpHit = cmpMatch[u] && !blocked[u] &&
                      (func == FN_CMP || func == FN_OFF);

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          pinPrev_reg[u] <= 1'b0;
        end else begin
          pinPrev_reg[u] <= pinIn[u];
        end
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          pinOut_reg[u] <= 1'b0;
        end else if (func == FN_CMP) begin
          if (!running[u]) begin
            pinOut_reg[u] <= field[u][`TCIO_FLD_INIT];
          end else if (cmpMatch[u]) begin
            case (field[u][1:0])
              `TCIO_ACT_LOW:    pinOut_reg[u] <= 1'b0;
              `TCIO_ACT_HIGH:   pinOut_reg[u] <= 1'b1;
              `TCIO_ACT_TOGGLE: pinOut_reg[u] <= !pinOut_reg[u];
              default:          pinOut_reg[u] <= pinOut_reg[u];
            endcase
          end
        end
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          pinOeN_reg[u] <= 1'b1;
        end else begin
          pinOeN_reg[u] <= (func != FN_CMP);
        end
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          capEvt_reg[u] <= 1'b0;
          capVal_reg[u] <= 16'h0000;
        end else begin
          capEvt_reg[u] <= capHit;
          if (capHit) begin
            capVal_reg[u] <= countOf[u];
          end
        end
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          cmpEvt_reg[u] <= 1'b0;
        end else begin
          cmpEvt_reg[u] <= cmpHit;
        end
      end

      assign pinOut[u]   = pinOut_reg[u];
      assign pinOeN[u]   = pinOeN_reg[u];
      assign capEvt[u]   = capEvt_reg[u];
      assign cmpEvt[u]   = cmpEvt_reg[u];
      assign capValue[u] = capVal_reg[u];
    end
  endgenerate

endmodule

`default_nettype wire

/* sim/tcio_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module tcio_assertions (
  input wire logic             sys_clk,
  input wire logic             arst_n,
  input wire logic [2:0]       regAddr,
  input wire logic [7:0]       regWrData,
  input wire logic             regWrStb,
  input wire logic [15:0]      ch2Count,
  input wire logic [4:0]       cmpMatch,
  input wire logic [4:0]       pinIn,
  input wire logic [4:0]       pinOut,
  input wire logic [4:0]       pinOeN,
  input wire logic [4:0]       capEvt,
  input wire logic [4:0]       cmpEvt,
  input wire logic [4:0][15:0] capValue
);
  // Shadow of written fields, so that predictions need no read traffic.
  logic [4:0][7:0] shReg;
  wire  [3:0]      f0 = shReg[0][3:0];
  wire  [3:0]      f3 = shReg[3][3:0];
  wire             cst0 = shReg[4][0];
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) shReg <= '0;
    else if (regWrStb && regAddr < 3'h5) shReg[regAddr] <= regWrData;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_hit; cmpMatch[0] && cst0 && !f0[3]; endsequence
  sequence s_edge3; f3[3] && pinIn[3] != $past(pinIn[3]); endsequence
  property p_off;
    s_hit ##0 (f0 == 4'h0) |=> cmpEvt[0] && pinOeN[0];
  endproperty
  a_off: assert property (p_off) else $error("off code misbehaves");
  property p_low; s_hit ##0 (f0[1:0] == 2'h1) |=> !pinOut[0]; endproperty
  a_low: assert property (p_low) else $error("pin not low");
  property p_high; s_hit ##0 (f0[1:0] == 2'h2) |=> pinOut[0]; endproperty
  a_high: assert property (p_high) else $error("pin not high");
  property p_tog;
    s_hit ##0 (f0[1:0] == 2'h3) |=> pinOut[0] != $past(pinOut[0]);
  endproperty
  a_tog: assert property (p_tog) else $error("pin not toggled");
  property p_init;
    !cst0 && !f0[3] && f0[1:0] != 2'h0 |=>
      !pinOeN[0] && pinOut[0] == $past(f0[2]);
  endproperty
  a_init: assert property (p_init) else $error("bad initial level");
  property p_rise;
    s_edge3 ##0 (f3[1:0] == 2'h0 && pinIn[3]) |=>
      capEvt[3] && capValue[3] == $past(ch2Count);
  endproperty
  a_rise: assert property (p_rise) else $error("rise missed");
  property p_fall;
    s_edge3 ##0 (f3[1:0] == 2'h1 && !pinIn[3]) |=> capEvt[3];
  endproperty
  a_fall: assert property (p_fall) else $error("fall missed");
  property p_both; s_edge3 ##0 f3[1] |=> capEvt[3]; endproperty
  a_both: assert property (p_both) else $error("edge missed");
  property p_own; pinIn[4] == $past(pinIn[4]) |=> !capEvt[4]; endproperty
  a_own: assert property (p_own) else $error("foreign capture");
  property p_buf;
    shReg[4][4] |=> !capEvt[1] && !cmpEvt[1] && pinOeN[1];
  endproperty
  a_buf: assert property (p_buf) else $error("buffer unit active");
endmodule
bind tcio_top tcio_assertions u_chk (.sys_clk, .arst_n, .regAddr, .regWrData,
  .regWrStb, .ch2Count, .cmpMatch, .pinIn, .pinOut, .pinOeN, .capEvt,
  .cmpEvt, .capValue);
`default_nettype wire

/* sim/tcio_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module tcio_pin_model (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [4:0] flip,
  input  wire logic [4:0] pinOut,
  input  wire logic [4:0] pinOeN,
  output logic      [4:0] pinIn
);
  logic [4:0] extReg;
  // Outside levels move only when a scenario asks for an edge.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) extReg <= 5'h00;
    else extReg <= extReg ^ flip;
  end
  // The wire shows the device while it drives, else the outside level.
  assign pinIn = (pinOut & ~pinOeN) | (extReg & pinOeN);
endmodule
`default_nettype wire

/* sim/tcio_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tcio_top_tb;
  logic            sys_clk, arst_n, regWrStb, regRdStb;
  logic [2:0]      regAddr;
  logic [7:0]      regWrData, regRdData;
  logic [15:0]     ch0Count, ch1Count, ch2Count;
  logic [4:0]      cmpMatch, pinIn, pinOut, pinOeN, capEvt, cmpEvt, flip;
  logic [4:0][15:0] capValue;
  int              failures, checksDone;
  // Rows: code, initial level, level after match, enable_n; no 11xx.
  logic [6:0] rows [8] = '{7'h01, 7'h08, 7'h12, 7'h1A,
                           7'h21, 7'h2C, 7'h36, 7'h3C};
  logic [5:0] caps [3] = '{6'h22, 6'h35, 6'h2B};
  tcio_top u_dut (.sys_clk, .arst_n, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .ch0Count, .ch1Count, .ch2Count, .cmpMatch,
    .pinIn, .pinOut, .pinOeN, .capEvt, .cmpEvt, .capValue);
  tcio_pin_model u_pins (.sys_clk, .arst_n, .flip, .pinOut, .pinOeN, .pinIn);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task print_verdict;
    if (failures == 0 && checksDone > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  // A flip needs one more edge: the pin model registers it before the pin moves.
  task hit(input logic [4:0] m, input logic f);
    @(posedge sys_clk);
    if (f) flip <= m;
    else cmpMatch <= m;
    @(posedge sys_clk);
    flip <= 5'h00;
    cmpMatch <= 5'h00;
    if (f) @(posedge sys_clk);
    #1;
  endtask
  task rst;
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
  endtask
  initial begin
    {regWrStb, regRdStb, regAddr, regWrData, cmpMatch, flip} = '0;
    {ch0Count, ch1Count, ch2Count} = {16'h0F00, 16'h0F01, 16'hA5C3};
    rst();
    chk(pinOeN, 5'h1F);
    for (int i = 0; i < 7; i++) rd(i[2:0], 8'h00);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    wr(3'h3, 8'h5A);
    rd(3'h3, 8'h5A);
    foreach (rows[i]) begin
      wr(3'h4, 8'h00);
      wr(3'h0, {4'h0, rows[i][6:3]});
      @(posedge sys_clk);
      #1 chk(pinOeN[0], rows[i][0]);
      if (!rows[i][0]) chk(pinOut[0], rows[i][2]);
      wr(3'h4, 8'h01);
      hit(5'h01, 1'b0);
      chk(cmpEvt[0], 1'b1);
      if (!rows[i][0]) chk(pinOut[0], rows[i][1]);
    end
    wr(3'h1, 8'h03);
    for (int b = 0; b < 2; b++) begin
      wr(3'h4, b ? 8'h01 : 8'h11);
      hit(5'h02, 1'b0);
      chk(cmpEvt[1], b[0]);
      chk(pinOeN[1], !b[0]);
    end
    foreach (caps[i]) begin
      wr(3'h3, {4'hA, caps[i][5:2]});
      for (int e = 0; e < 2; e++) begin
        hit(5'h08, 1'b1);
        chk(capEvt[3], caps[i][1-e]);
        chk(capEvt[4], 1'b0);
      end
    end
    chk(capValue[3], 16'hA5C3);
    wr(3'h2, 8'h05);
    @(posedge sys_clk);
    #1 chk(pinOeN[2], 1'b0);
    chk(pinOut[2], 1'b1);
    hit(5'h10, 1'b1);
    chk(capEvt[4], 1'b1);
    rst();
    chk(pinOeN, 5'h1F);
    rd(3'h3, 8'h00);
    print_verdict();
  end
  // Nothing here waits on the design, so a stuck run means a broken bench.
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
